// *** design/opcct_timer.sv ***
// Free-running 16-bit timer with capture, compare and one-pulse generation.
// Assumes a plain register port from logic on clk; pins are asynchronous.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "opcct_defines.svh"

module opcct_timer
    import opcct_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic trigger_input_pin,
    input wire logic second_capture_pin,
    output logic pulse_output_pin,
    output logic pulse_output_enable,
    output logic timer_irq
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [2:0] trig_sync_ff, nxt_trig_sync;
    logic [2:0] cap2_sync_ff, nxt_cap2_sync;

    always_comb begin
        nxt_trig_sync = {trig_sync_ff[1:0], trigger_input_pin};
        nxt_cap2_sync = {cap2_sync_ff[1:0], second_capture_pin};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trig_sync_ff <= 3'h0;
            cap2_sync_ff <= 3'h0;
        end else begin
            trig_sync_ff <= nxt_trig_sync;
            cap2_sync_ff <= nxt_cap2_sync;
        end
    end

    // ********************************
    // State
    // ********************************
    opcct_ctrl_a_t ctrl_a_ff, nxt_ctrl_a;
    opcct_ctrl_b_t ctrl_b_ff, nxt_ctrl_b;
    logic [3:0] flags_ff, nxt_flags;
    logic [3:0] armed_ff, nxt_armed;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] cap1_ff, nxt_cap1;
    logic [15:0] cap2_ff, nxt_cap2;
    logic [15:0] cmp1_ff, nxt_cmp1;
    logic [15:0] cmp2_ff, nxt_cmp2;
    logic pulse_level_ff, nxt_pulse_level;
    logic pin_en_ff, nxt_pin_en;
    logic irq_ff, nxt_irq;
    logic [7:0] rd_data_ff, nxt_rd_data;

    logic tick;
    logic opm_active;
    logic trig_edge;
    logic cap2_edge;
    logic opm_trig;
    logic cmp1_hit;
    logic cmp2_hit;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic status_rd;

    function automatic logic edge_seen(input logic [2:0] sync, input logic rising);
        edge_seen = rising ? (sync[1] & ~sync[2]) : (~sync[1] & sync[2]);
    endfunction

    function automatic logic touched(input logic [3:0] a, input logic acc,
                                     input logic [3:0] target);
        touched = acc && (a == target);
    endfunction

    // PWM takes precedence, so single-pulse logic is only live without it
    assign opm_active = ctrl_b_ff.single_pulse_select & ~ctrl_b_ff.pwm_select;
    assign trig_edge = edge_seen(trig_sync_ff, ctrl_a_ff.trigger_edge_select);
    assign cap2_edge = edge_seen(cap2_sync_ff, ctrl_a_ff.edge_two_select);
    assign opm_trig = opm_active & trig_edge;
    assign cmp1_hit = tick & (cnt_ff == cmp1_ff);
    assign cmp2_hit = tick & (cnt_ff == cmp2_ff);
    assign status_rd = touched(addr, rd_en, `OPCCT_ADDR_STATUS);

    opcct_prescaler #(
        .CNT_W(13)
    ) u_prescale_factor (
        .clk(clk),
        .nrst(nrst),
        .prescale_select(ctrl_b_ff.prescale_select),
        .restart(opm_trig),
        .tick(tick)
    );

    always_comb begin
        nxt_ctrl_a = ctrl_a_ff;
        nxt_ctrl_b = ctrl_b_ff;
        nxt_cmp1 = cmp1_ff;
        nxt_cmp2 = cmp2_ff;
        nxt_cap1 = cap1_ff;
        nxt_cap2 = cap2_ff;
        nxt_cnt = cnt_ff;
        nxt_pulse_level = pulse_level_ff;

        // Software writes
        if (wr_en) begin
            unique case (addr)
                `OPCCT_ADDR_CTRL_A: nxt_ctrl_a = opcct_ctrl_a_t'(wr_data);
                `OPCCT_ADDR_CTRL_B: nxt_ctrl_b = opcct_ctrl_b_t'(wr_data);
                `OPCCT_ADDR_CMP1_H: nxt_cmp1[15:8] = wr_data;
                `OPCCT_ADDR_CMP1_L: nxt_cmp1[7:0] = wr_data;
                `OPCCT_ADDR_CMP2_H: nxt_cmp2[15:8] = wr_data;
                `OPCCT_ADDR_CMP2_L: nxt_cmp2[7:0] = wr_data;
                default: ;
            endcase
        end

        // Counter: trigger reload beats the tick
        if (opm_trig) begin
            nxt_cnt = `OPCCT_TRIG_CNT_LOAD;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end

        // Capture one: fixed value in single-pulse mode, counter otherwise
        if (opm_trig) begin
            nxt_cap1 = `OPCCT_TRIG_CAP_LOAD;
        end else if (trig_edge) begin
            nxt_cap1 = cnt_ff;
        end
        if (cap2_edge) begin
            nxt_cap2 = cnt_ff;
        end

        // Output level; compare two never touches it
        if (opm_trig) begin
            nxt_pulse_level = ctrl_a_ff.during_pulse_level;
        end else if (cmp1_hit) begin
            nxt_pulse_level = ctrl_a_ff.after_pulse_level;
        end
    end

    // ********************************
    // Flags and two-step clear
    // ********************************
    always_comb begin
        flag_set = 4'h0;
        flag_set[`OPCCT_FLAG_CAP1] = trig_edge & (opm_active | ~ctrl_b_ff.single_pulse_select);
        flag_set[`OPCCT_FLAG_CMP1] = cmp1_hit & ~opm_active;
        flag_set[`OPCCT_FLAG_CAP2] = cap2_edge;
        flag_set[`OPCCT_FLAG_CMP2] = cmp2_hit;
        flag_clr = 4'h0;
        flag_clr[`OPCCT_FLAG_CAP1] = touched(addr, rd_en | wr_en, `OPCCT_ADDR_CAP1_L);
        flag_clr[`OPCCT_FLAG_CMP1] = touched(addr, rd_en | wr_en, `OPCCT_ADDR_CMP1_L);
        flag_clr[`OPCCT_FLAG_CAP2] = touched(addr, rd_en | wr_en, `OPCCT_ADDR_CAP2_L);
        flag_clr[`OPCCT_FLAG_CMP2] = touched(addr, rd_en | wr_en, `OPCCT_ADDR_CMP2_L);
        flag_clr = flag_clr & armed_ff;
        // A new event in the clearing cycle survives
        nxt_flags = (flags_ff & ~flag_clr) | flag_set;
        nxt_armed = armed_ff & ~flag_clr & nxt_flags;
        if (status_rd) begin
            nxt_armed = flags_ff & ~flag_clr;
        end
        nxt_irq = (ctrl_a_ff.capture_irq_enable
                   & (flags_ff[`OPCCT_FLAG_CAP1] | flags_ff[`OPCCT_FLAG_CAP2]))
                | (ctrl_a_ff.compare_irq_enable
                   & (flags_ff[`OPCCT_FLAG_CMP1] | flags_ff[`OPCCT_FLAG_CMP2]));
        nxt_pin_en = ctrl_b_ff.compare_pin_enable;
    end

    // ********************************
    // Read port
    // ********************************
    always_comb begin
        nxt_rd_data = 8'h00;
        if (rd_en) begin
            unique case (addr)
                `OPCCT_ADDR_CTRL_A: nxt_rd_data = ctrl_a_ff;
                `OPCCT_ADDR_CTRL_B: nxt_rd_data = ctrl_b_ff;
                `OPCCT_ADDR_STATUS: nxt_rd_data = {flags_ff, 4'h0};
                `OPCCT_ADDR_CAP1_H: nxt_rd_data = cap1_ff[15:8];
                `OPCCT_ADDR_CAP1_L: nxt_rd_data = cap1_ff[7:0];
                `OPCCT_ADDR_CMP1_H: nxt_rd_data = cmp1_ff[15:8];
                `OPCCT_ADDR_CMP1_L: nxt_rd_data = cmp1_ff[7:0];
                `OPCCT_ADDR_CAP2_H: nxt_rd_data = cap2_ff[15:8];
                `OPCCT_ADDR_CAP2_L: nxt_rd_data = cap2_ff[7:0];
                `OPCCT_ADDR_CMP2_H: nxt_rd_data = cmp2_ff[15:8];
                `OPCCT_ADDR_CMP2_L: nxt_rd_data = cmp2_ff[7:0];
                `OPCCT_ADDR_CNT_H: nxt_rd_data = cnt_ff[15:8];
                `OPCCT_ADDR_CNT_L: nxt_rd_data = cnt_ff[7:0];
                default: nxt_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_a_ff <= opcct_ctrl_a_t'(`OPCCT_RST_CTRL);
            ctrl_b_ff <= opcct_ctrl_b_t'(`OPCCT_RST_CTRL);
            cmp1_ff <= {`OPCCT_RST_CMP1_H, `OPCCT_RST_CMP1_L};
            cmp2_ff <= `OPCCT_RST_CMP2;
            cap1_ff <= `OPCCT_RST_CAP;
            cap2_ff <= `OPCCT_RST_CAP;
            cnt_ff <= `OPCCT_RST_CNT;
            flags_ff <= 4'h0;
            armed_ff <= 4'h0;
            pulse_level_ff <= 1'b0;
            pin_en_ff <= 1'b0;
            irq_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end else begin
            ctrl_a_ff <= nxt_ctrl_a;
            ctrl_b_ff <= nxt_ctrl_b;
            cmp1_ff <= nxt_cmp1;
            cmp2_ff <= nxt_cmp2;
            cap1_ff <= nxt_cap1;
            cap2_ff <= nxt_cap2;
            cnt_ff <= nxt_cnt;
            flags_ff <= nxt_flags;
            armed_ff <= nxt_armed;
            pulse_level_ff <= nxt_pulse_level;
            pin_en_ff <= nxt_pin_en;
            irq_ff <= nxt_irq;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
    assign pulse_output_pin = pulse_level_ff;
    assign pulse_output_enable = pin_en_ff;
    assign timer_irq = irq_ff;

    // ********************************
    // Assertions
    // ********************************
    property p_trigger_load;
        opm_trig |=> cnt_ff == `OPCCT_TRIG_CNT_LOAD && cap1_ff == `OPCCT_TRIG_CAP_LOAD
            && flags_ff[`OPCCT_FLAG_CAP1];
    endproperty
    a_trigger_load: assert property (p_trigger_load) else $error("Trigger load wrong");

    property p_during_level;
        opm_trig |=> pulse_output_pin == $past(ctrl_a_ff.during_pulse_level);
    endproperty
    a_during_level: assert property (p_during_level) else $error("During level not driven");

    property p_irq;
        ctrl_a_ff.capture_irq_enable && flags_ff[`OPCCT_FLAG_CAP1] |=> timer_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("Capture interrupt missing");

    sequence s_status_seen;
        status_rd && flags_ff[`OPCCT_FLAG_CAP1];
    endsequence
    sequence s_low_touch;
        (rd_en || wr_en) && addr == `OPCCT_ADDR_CAP1_L && !trig_edge;
    endsequence
    property p_two_step_clear;
        s_status_seen ##1 !trig_edge ##1 s_low_touch |=> !flags_ff[`OPCCT_FLAG_CAP1];
    endproperty
    a_two_step_clear: assert property (p_two_step_clear) else $error("Flag not cleared");

    property p_no_early_clear;
        flags_ff[`OPCCT_FLAG_CAP1] && !armed_ff[`OPCCT_FLAG_CAP1] && !status_rd
            |=> flags_ff[`OPCCT_FLAG_CAP1];
    endproperty
    a_no_early_clear: assert property (p_no_early_clear) else $error("Flag cleared early");

    property p_after_level;
        opm_active && cmp1_hit && !opm_trig
            |=> pulse_output_pin == $past(ctrl_a_ff.after_pulse_level);
    endproperty
    a_after_level: assert property (p_after_level) else $error("After level not driven");

    // Cycles since an undisturbed trigger at the shortest setting
    logic [3:0] short_age_ff, nxt_short_age;

    always_comb begin
        nxt_short_age = 4'h0;
        if (opm_trig && !wr_en && ctrl_b_ff.prescale_select == 2'h0
                && cmp1_ff == 16'h0000) begin
            nxt_short_age = 4'h1;
        end else if (short_age_ff != 4'h0 && short_age_ff != 4'hf && !wr_en && !opm_trig) begin
            nxt_short_age = short_age_ff + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            short_age_ff <= 4'h0;
        end else begin
            short_age_ff <= nxt_short_age;
        end
    end

    sequence s_short_pulse;
        short_age_ff == 4'ha && !wr_en && !opm_trig;
    endsequence
    property p_pulse_width;
        s_short_pulse |-> pulse_level_ff == ctrl_a_ff.during_pulse_level
            ##1 pulse_level_ff == ctrl_a_ff.after_pulse_level;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("Pulse width wrong");

    property p_no_cmp1_flag;
        opm_active && !flags_ff[`OPCCT_FLAG_CMP1] |=> !flags_ff[`OPCCT_FLAG_CMP1];
    endproperty
    a_no_cmp1_flag: assert property (p_no_cmp1_flag) else $error("Compare one flag set");

    property p_pwm_wins;
        ctrl_b_ff.pwm_select && trig_edge && !tick |=> cnt_ff == $past(cnt_ff);
    endproperty
    a_pwm_wins: assert property (p_pwm_wins) else $error("Trigger acted under PWM");

    property p_const_level;
        opm_active && ctrl_a_ff.during_pulse_level == ctrl_a_ff.after_pulse_level
            && pulse_level_ff == ctrl_a_ff.after_pulse_level && !wr_en
            |=> $stable(pulse_level_ff);
    endproperty
    a_const_level: assert property (p_const_level) else $error("Level moved");

    property p_cap2;
        cap2_edge |=> cap2_ff == $past(cnt_ff) && flags_ff[`OPCCT_FLAG_CAP2];
    endproperty
    a_cap2: assert property (p_cap2) else $error("Second capture wrong");

    property p_count;
        tick && !opm_trig |=> cnt_ff == $past(cnt_ff) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("Counter did not step");

endmodule

// *** include/opcct_defines.svh ***
// Constants of the one-pulse capture/compare timer: offsets, reset values,
// flag positions and timing counts. Included by the package, the timer, the prescaler and the bench.
`ifndef OPCCT_DEFINES_SVH
`define OPCCT_DEFINES_SVH

// ********************************
// Register offsets
// ********************************
`define OPCCT_ADDR_CTRL_A 4'h0
`define OPCCT_ADDR_CTRL_B 4'h1
`define OPCCT_ADDR_STATUS 4'h2
`define OPCCT_ADDR_CAP1_H 4'h3
`define OPCCT_ADDR_CAP1_L 4'h4
`define OPCCT_ADDR_CMP1_H 4'h5
`define OPCCT_ADDR_CMP1_L 4'h6
`define OPCCT_ADDR_CAP2_H 4'h7
`define OPCCT_ADDR_CAP2_L 4'h8
`define OPCCT_ADDR_CMP2_H 4'h9
`define OPCCT_ADDR_CMP2_L 4'ha
`define OPCCT_ADDR_CNT_H 4'hb
`define OPCCT_ADDR_CNT_L 4'hc

// ********************************
// Reset values
// ********************************
`define OPCCT_RST_CTRL 8'h00
`define OPCCT_RST_CMP1_H 8'h80
`define OPCCT_RST_CMP1_L 8'h00
`define OPCCT_RST_CMP2 16'hffff
`define OPCCT_RST_CAP 16'h0000
`define OPCCT_RST_CNT 16'hfffc

// ********************************
// Flag positions inside the 4-bit flag vector (status bits 7:4)
// ********************************
`define OPCCT_FLAG_CAP1 3
`define OPCCT_FLAG_CMP1 2
`define OPCCT_FLAG_CAP2 1
`define OPCCT_FLAG_CMP2 0

// ********************************
// Trigger load values and prescaler factors
// ********************************
`define OPCCT_TRIG_CNT_LOAD 16'hfffc
`define OPCCT_TRIG_CAP_LOAD 16'hfffd
`define OPCCT_PRESCALE_FACTOR_F0 13'h0002
`define OPCCT_PRESCALE_FACTOR_F1 13'h0004
`define OPCCT_PRESCALE_FACTOR_F2 13'h0008
`define OPCCT_PRESCALE_FACTOR_F3 13'h1f40
`define OPCCT_PRESCALE_FACTOR_RESTART 13'h0001

`endif

// *** include/opcct_pkg.sv ***
// Types of the one-pulse capture/compare timer.
// Assumes opcct_defines.svh is on the include path.
`include "opcct_defines.svh"

package opcct_pkg;

    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic [1:0] spare;
        logic edge_two_select;
        logic trigger_edge_select;
        logic during_pulse_level;
        logic after_pulse_level;
    } opcct_ctrl_a_t;

    typedef struct packed {
        logic compare_pin_enable;
        logic spare_hi;
        logic pwm_select;
        logic single_pulse_select;
        logic [1:0] spare_lo;
        logic [1:0] prescale_select;
    } opcct_ctrl_b_t;

endpackage

// *** design/opcct_prescaler.sv ***
// Prescaler of the timer: one-cycle tick every 2, 4, 8 or 8000 clocks.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/1ps
`include "opcct_defines.svh"

module opcct_prescaler
    import opcct_pkg::*;
#(
    parameter int CNT_W = 13
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] prescale_select,
    input wire logic restart,
    output logic tick
);

    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic tick_ff, nxt_tick;
    logic [CNT_W-1:0] factor;

    // ********************************
    // Divider
    // ********************************
    always_comb begin
        unique case (prescale_select)
            2'h0: factor = CNT_W'(`OPCCT_PRESCALE_FACTOR_F0);
            2'h1: factor = CNT_W'(`OPCCT_PRESCALE_FACTOR_F1);
            2'h2: factor = CNT_W'(`OPCCT_PRESCALE_FACTOR_F2);
            2'h3: factor = CNT_W'(`OPCCT_PRESCALE_FACTOR_F3);
        endcase
        nxt_tick = 1'b0;
        nxt_cnt = cnt_ff + CNT_W'(1);
        // Restart at 1 so the first tick lands a full factor after the trigger
        if (restart) begin
            nxt_cnt = CNT_W'(`OPCCT_PRESCALE_FACTOR_RESTART);
        end else if (cnt_ff >= factor - CNT_W'(1)) begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    property p_tick_single;
        @(posedge clk) disable iff (!nrst) tick_ff |=> !tick_ff;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("Prescaler tick longer than one cycle");

endmodule

// *** dv/opcct_event_source.sv ***
// Far side of the timer: event source on both capture pins, and a load
// that times each level of the pulse pin. Assumes clk is shared with the bench.
`timescale 1ns/1ps

module opcct_event_source (
    input wire logic clk,
    input wire logic nrst,
    input wire logic fire_one,
    input wire logic fire_two,
    input wire logic active_one,
    input wire logic active_two,
    output logic trigger_input_pin,
    output logic second_capture_pin,
    input wire logic pulse_output_pin,
    input wire logic pulse_output_enable,
    output int width_seen,
    output int transitions
);
    int hold_one;
    int hold_two;
    int run_len;
    logic last_level;

    // ************************************************
    // Event pins
    // ************************************************
    // Pins rest at the inactive level; three clocks active outlast the synchroniser
    assign trigger_input_pin = (hold_one > 0) ? active_one : !active_one;
    assign second_capture_pin = (hold_two > 0) ? active_two : !active_two;

    // ************************************************
    // Pulse load
    // ************************************************
    // A level change only ends and records a run while the pin is dedicated to compare one
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_one <= 0;
            hold_two <= 0;
            run_len <= 0;
            width_seen <= 0;
            transitions <= 0;
            last_level <= 1'b0;
        end else begin
            hold_one <= fire_one ? 3 : ((hold_one > 0) ? hold_one - 1 : 0);
            hold_two <= fire_two ? 3 : ((hold_two > 0) ? hold_two - 1 : 0);
            if (pulse_output_enable && (pulse_output_pin !== last_level)) begin
                width_seen <= run_len;
                transitions <= transitions + 1;
                run_len <= 1;
            end else begin
                run_len <= run_len + 1;
            end
            last_level <= pulse_output_pin;
        end
    end
endmodule

// *** dv/opcct_timer_bench.sv ***
// Self-checking bench of the one-pulse timer: register port tasks, one task
// per scenario. Assumes the event source model sits on the capture pins.
`timescale 1ns/1ps
`include "opcct_defines.svh"

module opcct_timer_bench;
    logic clk;
    logic nrst;
    logic [3:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    logic trig_pin;
    logic cap2_pin;
    logic pulse_pin;
    logic pulse_oe;
    logic timer_irq;
    logic fire_one;
    logic fire_two;
    logic active_one;
    logic active_two;
    int width_seen;
    int transitions;
    int mismatches;
    int check_count;
    int cycles;

    opcct_timer dut (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .trigger_input_pin(trig_pin),
        .second_capture_pin(cap2_pin), .pulse_output_pin(pulse_pin),
        .pulse_output_enable(pulse_oe), .timer_irq(timer_irq));

    opcct_event_source far_side (.clk(clk), .nrst(nrst), .fire_one(fire_one),
        .fire_two(fire_two), .active_one(active_one), .active_two(active_two),
        .trigger_input_pin(trig_pin), .second_capture_pin(cap2_pin),
        .pulse_output_pin(pulse_pin), .pulse_output_enable(pulse_oe),
        .width_seen(width_seen), .transitions(transitions));

    // ************************************************
    // Clock, timeout and verdict
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The slowest prescaler alone needs 40000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // ************************************************
    // Register port and event helpers
    // ************************************************
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic fire(input logic one, input logic two);
        @(posedge clk);
        fire_one <= one;
        fire_two <= two;
        @(posedge clk);
        fire_one <= 1'b0;
        fire_two <= 1'b0;
    endtask

    task automatic wait_transitions(input int target);
        int n;
        n = 0;
        while (transitions < target && n < 50000) begin
            @(posedge clk);
            n++;
        end
        check("pulse ended", 32'(transitions >= target), 32'h1);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_registers();
        logic [7:0] d;
        reg_rd(`OPCCT_ADDR_CMP1_H, d);
        check("cmp1 high reset", d, 8'h80);
        reg_rd(`OPCCT_ADDR_CMP1_L, d);
        check("cmp1 low reset", d, 8'h00);
        reg_wr(`OPCCT_ADDR_CMP1_H, 8'h12);
        reg_wr(`OPCCT_ADDR_CMP1_L, 8'h34);
        reg_rd(`OPCCT_ADDR_CMP1_H, d);
        check("cmp1 high rw", d, 8'h12);
        reg_rd(`OPCCT_ADDR_CMP1_L, d);
        check("cmp1 low rw", d, 8'h34);
        reg_wr(`OPCCT_ADDR_CAP1_H, 8'h5a);
        reg_rd(`OPCCT_ADDR_CAP1_H, d);
        check("cap1 high read only", d, 8'h00);
        reg_rd(4'hd, d);
        check("unmapped read", d, 8'h00);
    endtask

    // Software picks levels and edge before the pin and mode bits go on together
    task automatic t_one_pulse(input logic [1:0] sel, input logic [7:0] v, input int f);
        logic [7:0] d;
        int t0;
        reg_wr(`OPCCT_ADDR_CTRL_A, 8'h8e);
        reg_wr(`OPCCT_ADDR_CMP1_H, 8'h00);
        reg_wr(`OPCCT_ADDR_CMP1_L, v);
        reg_wr(`OPCCT_ADDR_CTRL_B, 8'h90 | {6'h00, sel});
        repeat (2) @(posedge clk);
        check("pin enable", pulse_oe, 1'b1);
        t0 = transitions;
        fire(1'b1, 1'b0);
        wait_transitions(t0 + 2);
        check("pulse width", width_seen, f * (v + 5));
        check("after level", pulse_pin, 1'b0);
        check("capture irq", timer_irq, 1'b1);
        reg_rd(`OPCCT_ADDR_CAP1_H, d);
        check("cap1 high load", d, 8'hff);
        reg_rd(`OPCCT_ADDR_CAP1_L, d);
        check("cap1 low load", d, 8'hfd);
        reg_rd(`OPCCT_ADDR_STATUS, d);
        check("flags unarmed", d[7:6], 2'b10);
        reg_wr(`OPCCT_ADDR_CAP1_L, 8'h55);
        reg_rd(`OPCCT_ADDR_STATUS, d);
        check("cap1 flag clear", d[7], 1'b0);
        reg_rd(`OPCCT_ADDR_CAP1_L, d);
        check("cap1 low kept", d, 8'hfd);
        check("irq dropped", timer_irq, 1'b0);
    endtask

    task automatic t_equal_levels();
        logic [7:0] d;
        int bad;
        int t0;
        reg_wr(`OPCCT_ADDR_CTRL_A, 8'h0b);
        active_one <= 1'b0;
        reg_wr(`OPCCT_ADDR_CTRL_B, 8'h92);
        fire(1'b1, 1'b0);
        repeat (6) @(posedge clk);
        t0 = transitions;
        bad = 0;
        repeat (60) begin
            @(posedge clk);
            bad += (pulse_pin !== 1'b1);
        end
        check("constant level", 32'(bad), 32'h0);
        check("no edges", 32'(transitions - t0), 32'h0);
        reg_rd(`OPCCT_ADDR_STATUS, d);
        check("falling trigger flag", d[7], 1'b1);
        reg_rd(`OPCCT_ADDR_CAP1_L, d);
    endtask

    // Second edge at 10 cycles restarts the count mid-pulse
    task automatic t_retrigger();
        int t0;
        reg_wr(`OPCCT_ADDR_CTRL_A, 8'h8e);
        active_one <= 1'b1;
        reg_wr(`OPCCT_ADDR_CMP1_L, 8'h03);
        reg_wr(`OPCCT_ADDR_CTRL_B, 8'h90);
        // Park the pin at the new after level first
        fire(1'b1, 1'b0);
        repeat (40) @(posedge clk);
        t0 = transitions;
        fire(1'b1, 1'b0);
        repeat (8) @(posedge clk);
        fire(1'b1, 1'b0);
        wait_transitions(t0 + 2);
        check("retrigger width", width_seen, 32'd26);
    endtask

    task automatic t_second_channel();
        logic [7:0] d;
        int t0;
        // Arm the stale compare two flag so the low byte write clears it
        reg_rd(`OPCCT_ADDR_STATUS, d);
        reg_wr(`OPCCT_ADDR_CMP2_H, 8'h00);
        reg_wr(`OPCCT_ADDR_CMP2_L, 8'h30);
        t0 = transitions;
        fire(1'b1, 1'b1);
        repeat (200) @(posedge clk);
        reg_rd(`OPCCT_ADDR_STATUS, d);
        check("status flags", d[7:4], 4'hb);
        check("only one pulse", 32'(transitions - t0), 32'h2);
        check("pin at after level", pulse_pin, 1'b0);
    endtask

    task automatic t_pwm_wins();
        logic [7:0] d;
        int t0;
        reg_rd(`OPCCT_ADDR_CAP1_L, d);
        reg_wr(`OPCCT_ADDR_CTRL_B, 8'hb0);
        t0 = transitions;
        fire(1'b1, 1'b0);
        repeat (30) @(posedge clk);
        reg_rd(`OPCCT_ADDR_STATUS, d);
        check("pwm trigger flag", d[7], 1'b0);
        check("pwm no pulse", 32'(transitions - t0), 32'h0);
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        fire_one = 1'b0;
        fire_two = 1'b0;
        active_one = 1'b1;
        active_two = 1'b1;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_registers();
        t_one_pulse(2'h0, 8'h00, 2);
        t_one_pulse(2'h1, 8'h01, 4);
        t_one_pulse(2'h2, 8'h00, 8);
        t_one_pulse(2'h3, 8'h00, 8000);
        t_equal_levels();
        t_retrigger();
        t_second_channel();
        t_pwm_wins();
        conclude();
    end
endmodule
